// ==== eqc_smbus_regs.sv ====
`timescale 1ns/1ps
// Operation
// - device acknowledges its own address with write bit by driving low.
// - host sends register index; device acknowledges and keeps it for reading.
// - after acknowledging read address, device shifts out indexed register byte.
// - at end of a read device releases data line and goes idle.
// - index zero shows lane detect flags low nibble, revision high nibble.
// - indices one and two show effective enable and boost per lane.
// - indices three and four hold disable bits and boost, reset 0x44.
// - index five holds two-bit assert threshold select per lane, reset zero.
// - index six holds two-bit deassert threshold select per lane, reset zero.
// - index seven bit zero selects register lane enable control, reset zero.
// - index eight bits three to two hold output swing, reset 0x78.
// - writes never alter read-only registers; writable bits read back written data, other bits keep reset value.
// - while chip select is low all bus traffic is ignored.
// - device answers only slave address 1010110.
// - write: address, index, data, each acknowledged, data stored in register.
// - source bit zero: enable follows pin; one: enable is the inverse of the register disable bit.
module eqc_smbus_regs (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        chipSelect,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic [3:0]  laneSignalPresent,
  input  wire logic [3:0]  laneOutputOnPin,
  output logic      [3:0]  laneOutputOn,
  output logic      [11:0] laneBoost,
  output logic      [7:0]  detectAssertLevel,
  output logic      [7:0]  detectDeassertLevel,
  output logic      [1:0]  driverSwing
);
  eqc_reg_if rif ();

  logic [eqc_pkg::SYNC_WIDTH-1:0] syncOut;
  logic                           sclQ;
  logic                           sdaQ;
  eqc_pkg::eqc_state_type         state;
  eqc_pkg::eqc_state_type         next_state;
  logic [3:0]                     bitCnt;
  logic [3:0]                     next_bitCnt;
  logic [7:0]                     rxShift;
  logic [7:0]                     next_rxShift;
  logic [7:0]                     txShift;
  logic [7:0]                     next_txShift;
  logic [7:0]                     index;
  logic [7:0]                     next_index;
  logic [7:0]                     wrData;
  logic [7:0]                     next_wrData;
  logic                           wrEn;
  logic                           next_wrEn;
  logic                           readDir;
  logic                           next_readDir;
  logic                           next_oe;
  logic [3:0]                     laneOnNow;

  eqc_pin_sync #(
    .WIDTH (eqc_pkg::SYNC_WIDTH)
  ) u_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn ({laneSignalPresent, laneOutputOnPin, chipSelect, sdaIn, sclIn}),
    .syncOut (syncOut)
  );

  eqc_reg_bank u_bank (
    .clk   (clk),
    .rst_b (rst_b),
    .rif   (rif)
  );

  wire       sclS       = syncOut[0];
  wire       sdaS       = syncOut[1];
  wire       csS        = syncOut[2];
  wire [3:0] pinS       = syncOut[6:3];
  wire [3:0] presentS   = syncOut[10:7];

  // bus conditions seen on the sampled lines
  wire       sclRise    = sclS & ~sclQ;
  wire       sclFall    = ~sclS & sclQ;
  wire       startSeen  = csS & sclS & sclQ & sdaQ & ~sdaS;
  wire       stopSeen   = csS & sclS & sclQ & ~sdaQ & sdaS;
  wire [7:0] rxByte     = {rxShift[6:0], sdaS};
  wire       active     = (state != eqc_pkg::ST_IDLE);
  wire       rxState    = (state == eqc_pkg::ST_ADDR) || (state == eqc_pkg::ST_INDEX)
                       || (state == eqc_pkg::ST_WDATA);
  wire       byteIn     = sclRise && rxState && (bitCnt == eqc_pkg::BIT_LAST);
  wire       addrHit    = (rxByte[7:1] == eqc_pkg::SLAVE_ADDRESS);
  wire       hostAckBit = sclRise && (state == eqc_pkg::ST_RDATA)
                       && (bitCnt == eqc_pkg::BIT_ACK_DRIVE);
  wire       ackFall    = sclFall && active && (bitCnt == eqc_pkg::BIT_ACK_DRIVE);
  wire       doneFall   = sclFall && active && (bitCnt == eqc_pkg::BIT_ACK_DONE);
  wire       loadTx     = doneFall && ((state == eqc_pkg::ST_RDATA)
                       || ((state == eqc_pkg::ST_ADDR) && readDir));
  wire       sourceReg  = rif.sourceSel[eqc_pkg::SOURCE_SELECT_BIT];

  // effective lane enable per lane
  genvar l;
  generate
    for (l = 0; l < eqc_pkg::LANES; l++)
    begin : g_lane
      wire [7:0] ctl     = (l < 2) ? rif.lane01Ctl : rif.lane23Ctl;
      wire       regEnable = ~(((l % 2) == 1) ? ctl[eqc_pkg::UPPER_DISABLE_BIT]
                                               : ctl[eqc_pkg::LOWER_DISABLE_BIT]);
      assign laneOnNow[l] = sourceReg ? regEnable : pinS[l];
    end
  endgenerate

  assign rif.wrEn        = wrEn;
  assign rif.index       = index;
  assign rif.wrData      = wrData;
  assign rif.detectFlags = presentS;
  assign rif.laneOn      = laneOutputOn;

  always_comb
  begin
    next_state   = state;
    next_bitCnt  = bitCnt;
    next_rxShift = rxShift;
    next_txShift = txShift;
    next_index   = index;
    next_wrData  = wrData;
    next_readDir = readDir;
    next_oe      = sdaOe;
    next_wrEn    = 1'b0;
    if (!csS || stopSeen)
    begin
      next_state  = eqc_pkg::ST_IDLE;
      next_bitCnt = 4'h0;
      next_oe     = 1'b0;
    end
    else if (startSeen)
    begin
      next_state  = eqc_pkg::ST_ADDR;
      next_bitCnt = 4'h0;
      next_oe     = 1'b0;
    end
    else if (sclRise && active)
    begin
      if (bitCnt < eqc_pkg::BIT_ACK_DRIVE)
      begin
        next_rxShift = rxByte;
        next_bitCnt  = 4'(bitCnt + 4'h1);
      end
      else
        next_bitCnt = eqc_pkg::BIT_ACK_DONE;
      if (byteIn)
      begin
        case (state)
          eqc_pkg::ST_ADDR:
          begin
            if (!addrHit)
              next_state = eqc_pkg::ST_IDLE;
            next_readDir = rxByte[0];
          end
          eqc_pkg::ST_INDEX:
            next_index = rxByte;
          eqc_pkg::ST_WDATA:
          begin
            next_wrData = rxByte;
            next_wrEn   = 1'b1;
          end
          default:
            next_state = state;
        endcase
      end
      if (hostAckBit)
      begin
        if (sdaS)
          next_state = eqc_pkg::ST_IDLE;
        else
          next_index = 8'(index + 8'h01);
      end
    end
    else if (sclFall && active)
    begin
      if (ackFall)
        next_oe = (state != eqc_pkg::ST_RDATA);
      else if (doneFall)
      begin
        next_bitCnt = 4'h0;
        next_oe     = 1'b0;
        case (state)
          eqc_pkg::ST_ADDR:
            next_state = readDir ? eqc_pkg::ST_RDATA : eqc_pkg::ST_INDEX;
          eqc_pkg::ST_INDEX:
            next_state = eqc_pkg::ST_WDATA;
          eqc_pkg::ST_WDATA:
            next_index = 8'(index + 8'h01);
          default:
            next_state = state;
        endcase
        if (loadTx)
        begin
          next_oe      = ~rif.rdData[7];
          next_txShift = {rif.rdData[6:0], 1'b0};
        end
      end
      else if (state == eqc_pkg::ST_RDATA)
      begin
        next_oe      = ~txShift[7];
        next_txShift = {txShift[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state   <= eqc_pkg::ST_IDLE;
      bitCnt  <= 4'h0;
      rxShift <= 8'h00;
      txShift <= 8'h00;
      index   <= 8'h00;
      wrData  <= 8'h00;
      wrEn    <= 1'b0;
      readDir <= 1'b0;
      sdaOe   <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      bitCnt  <= next_bitCnt;
      rxShift <= next_rxShift;
      txShift <= next_txShift;
      index   <= next_index;
      wrData  <= next_wrData;
      wrEn    <= next_wrEn;
      readDir <= next_readDir;
      sdaOe   <= next_oe;
    end
  end

  // registered outputs; bus keeps running in lane standby
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sclQ                <= 1'b1;
      sdaQ                <= 1'b1;
      sdaOut              <= 1'b0;
      laneOutputOn        <= 4'h0;
      laneBoost           <= 12'h000;
      detectAssertLevel   <= 8'h00;
      detectDeassertLevel <= 8'h00;
      driverSwing         <= 2'h0;
    end
    else
    begin
      sclQ                <= sclS;
      sdaQ                <= sdaS;
      sdaOut              <= 1'b0;
      laneOutputOn        <= laneOnNow;
      laneBoost           <= {rif.lane23Ctl[6:4], rif.lane23Ctl[2:0],
                              rif.lane01Ctl[6:4], rif.lane01Ctl[2:0]};
      detectAssertLevel   <= rif.assertSel;
      detectDeassertLevel <= rif.deassertSel;
      driverSwing         <= rif.swingSel[eqc_pkg::SWING_MSB:eqc_pkg::SWING_LSB];
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_addr_ack;
    (state == eqc_pkg::ST_ADDR) && ackFall && csS && !startSeen && !stopSeen |=> sdaOe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

  property p_index_kept;
    byteIn && (state == eqc_pkg::ST_INDEX) && csS && !startSeen && !stopSeen
      |=> index == $past(rxByte);
  endproperty
  a_index_kept: assert property (p_index_kept) else $error("index not kept");

  property p_first_bit;
    loadTx && csS && !startSeen && !stopSeen |=> sdaOe == ~$past(rif.rdData[7]);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("wrong first read bit");

  property p_stop_release;
    stopSeen |=> !sdaOe && (state == eqc_pkg::ST_IDLE);
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("bus not released");

  property p_cs_low_quiet;
    !csS [*2] |-> !sdaOe && (state == eqc_pkg::ST_IDLE);
  endproperty
  a_cs_low_quiet: assert property (p_cs_low_quiet) else $error("active with select low");

  property p_foreign_addr;
    byteIn && (state == eqc_pkg::ST_ADDR) && !addrHit && csS && !startSeen && !stopSeen
      |=> state == eqc_pkg::ST_IDLE;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address taken");

  property p_write_store;
    wrEn && (index == eqc_pkg::IDX_LANE01_CTL) |=> rif.lane01Ctl == $past(wrData);
  endproperty
  a_write_store: assert property (p_write_store) else $error("write not stored");

  property p_unmapped_zero;
    (index > eqc_pkg::IDX_LAST) |-> rif.rdData == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped not zero");

  property p_swing_reserved;
    (rif.swingSel & ~eqc_pkg::WRITE_MASK[8])
      == (eqc_pkg::RESET_VALUE[8] & ~eqc_pkg::WRITE_MASK[8]);
  endproperty
  a_swing_reserved: assert property (p_swing_reserved) else $error("swing reserved");

  property p_pin_source;
    !sourceReg && $stable(pinS) && $stable(sourceReg) |=> laneOutputOn == $past(pinS);
  endproperty
  a_pin_source: assert property (p_pin_source) else $error("enable not from pin");

  property p_source_bit_only;
    (rif.sourceSel & 8'hFE) == 8'h00;
  endproperty
  a_source_bit_only: assert property (p_source_bit_only) else $error("source bits set");

  property p_nack_idle;
    hostAckBit && sdaS && csS |=> !sdaOe && (state == eqc_pkg::ST_IDLE);
  endproperty
  a_nack_idle: assert property (p_nack_idle) else $error("read not ended");

  c_write: cover property (wrEn);
  c_read_load: cover property (loadTx);
  c_host_nack: cover property (hostAckBit && sdaS);
  c_repeated_start: cover property (startSeen && (state == eqc_pkg::ST_WDATA));
endmodule // eqc_smbus_regs

// ==== eqc_pkg.sv ====
package eqc_pkg;

  // fixed slave address 1010110
  localparam logic [6:0] SLAVE_ADDRESS = 7'h56;

  // revision nibble: value is arbitrary
  localparam logic [3:0] REVISION_ID = 4'h1;

  // register indices
  localparam logic [7:0] IDX_DETECT_REV     = 8'h00;
  localparam logic [7:0] IDX_LANE01_STATE   = 8'h01;
  localparam logic [7:0] IDX_LANE23_STATE   = 8'h02;
  localparam logic [7:0] IDX_LANE01_CTL     = 8'h03;
  localparam logic [7:0] IDX_LANE23_CTL     = 8'h04;
  localparam logic [7:0] IDX_ASSERT_LEVEL   = 8'h05;
  localparam logic [7:0] IDX_DEASSERT_LEVEL = 8'h06;
  localparam logic [7:0] IDX_SOURCE_SELECT  = 8'h07;
  localparam logic [7:0] IDX_SWING_SELECT   = 8'h08;
  localparam logic [7:0] IDX_FIRST_RW       = 8'h03;
  localparam logic [7:0] IDX_LAST           = 8'h08;
  localparam int         REG_COUNT          = 9;

  // reset values and writable bits, entry n belongs to index n
  localparam logic [8:0][7:0] RESET_VALUE = {8'h78, 8'h00, 8'h00, 8'h00, 8'h44,
                                             8'h44, 8'h00, 8'h00, 8'h00};
  localparam logic [8:0][7:0] WRITE_MASK  = {8'h0C, 8'h01, 8'hFF, 8'hFF, 8'hFF,
                                             8'hFF, 8'h00, 8'h00, 8'h00};

  // field positions
  localparam int SOURCE_SELECT_BIT = 0;
  localparam int SWING_LSB         = 2;
  localparam int SWING_MSB         = 3;
  localparam int UPPER_DISABLE_BIT = 7;
  localparam int LOWER_DISABLE_BIT = 3;

  // bit counter landmarks within a byte frame
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [3:0] BIT_ACK_DRIVE = 4'h8;
  localparam logic [3:0] BIT_ACK_DONE  = 4'h9;

  localparam int LANES      = 4;
  localparam int SYNC_WIDTH = 11;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_INDEX,
    ST_WDATA,
    ST_RDATA
  } eqc_state_type;

endpackage

// ==== eqc_reg_if.sv ====
`timescale 1ns/1ps
interface eqc_reg_if;
  logic       wrEn;
  logic [7:0] index;
  logic [7:0] wrData;
  logic [7:0] rdData;
  logic [3:0] detectFlags;
  logic [3:0] laneOn;
  logic [7:0] lane01Ctl;
  logic [7:0] lane23Ctl;
  logic [7:0] assertSel;
  logic [7:0] deassertSel;
  logic [7:0] sourceSel;
  logic [7:0] swingSel;

  modport bank (
    input  wrEn, index, wrData, detectFlags, laneOn,
    output rdData, lane01Ctl, lane23Ctl, assertSel, deassertSel, sourceSel, swingSel
  );
  modport engine (
    output wrEn, index, wrData, detectFlags, laneOn,
    input  rdData, lane01Ctl, lane23Ctl, assertSel, deassertSel, sourceSel, swingSel
  );
endinterface // eqc_reg_if

// ==== eqc_pin_sync.sv ====
`timescale 1ns/1ps
module eqc_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  // two flops; stage1 feeds only the second flop
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      stage1  <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule // eqc_pin_sync

// ==== eqc_reg_bank.sv ====
`timescale 1ns/1ps
module eqc_reg_bank (
  input  wire logic clk,
  input  wire logic rst_b,
  eqc_reg_if.bank   rif
);
  logic [7:0] regView [0:eqc_pkg::REG_COUNT-1];

  // read-only status views
  assign regView[0] = {eqc_pkg::REVISION_ID, rif.detectFlags};
  assign regView[1] = {rif.laneOn[1], rif.lane01Ctl[6:4],
                       rif.laneOn[0], rif.lane01Ctl[2:0]};
  assign regView[2] = {rif.laneOn[3], rif.lane23Ctl[6:4],
                       rif.laneOn[2], rif.lane23Ctl[2:0]};

  genvar g;
  generate
    for (g = 3; g < eqc_pkg::REG_COUNT; g++)
    begin : g_rw
      logic [7:0] value;
      wire        hit = rif.wrEn && (rif.index == 8'(g));
      wire [7:0]  next_value = (value & ~eqc_pkg::WRITE_MASK[g])
                             | (rif.wrData & eqc_pkg::WRITE_MASK[g]);
      always_ff @(posedge clk)
      begin
        if (!rst_b)
          value <= eqc_pkg::RESET_VALUE[g];
        else if (hit)
          value <= next_value;
      end
      assign regView[g] = value;
    end
  endgenerate

  assign rif.lane01Ctl   = regView[3];
  assign rif.lane23Ctl   = regView[4];
  assign rif.assertSel   = regView[5];
  assign rif.deassertSel = regView[6];
  assign rif.sourceSel   = regView[7];
  assign rif.swingSel    = regView[8];

  wire inRange = (rif.index <= eqc_pkg::IDX_LAST);
  assign rif.rdData = inRange ? regView[rif.index[3:0]] : 8'h00;
endmodule // eqc_reg_bank

// ==== eqc_host_model.sv ====
`timescale 1ns/1ps
module eqc_host_model (
  input  wire logic clk,
  input  wire logic sdaOe,
  input  wire logic sdaOut,
  output logic      chipSelect,
  output logic      sclIn,
  output logic      sdaLine
);
  logic hostSda;

  // wired-and with pull-up: a released line reads high
  assign sdaLine = hostSda & ~(sdaOe & ~sdaOut);

  initial
  begin
    chipSelect = 1'b0;
    sclIn      = 1'b1;
    hostSda    = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // start or repeated start: data falls while clock high
  task automatic start_cond();
    hostSda = 1'b1;
    tick(4);
    sclIn = 1'b1;
    tick(4);
    hostSda = 1'b0;
    tick(4);
    sclIn = 1'b0;
    tick(2);
  endtask

  task automatic stop_cond();
    hostSda = 1'b0;
    tick(2);
    sclIn = 1'b1;
    tick(4);
    hostSda = 1'b1;
    tick(4);
  endtask

  // one bit is 8 clocks: 200 ns link clock, 100 ns low and 100 ns high
  task automatic send_bit(input logic b);
    hostSda = b;
    tick(2);
    sclIn = 1'b1;
    tick(4);
    sclIn = 1'b0;
    tick(2);
  endtask

  task automatic recv_bit(output logic b);
    hostSda = 1'b1;
    tick(2);
    sclIn = 1'b1;
    tick(2);
    b = sdaLine;
    tick(2);
    sclIn = 1'b0;
    tick(2);
  endtask

  task automatic send_byte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--)
      send_bit(v[i]);
    recv_bit(ack);
  endtask

  task automatic recv_byte(output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      recv_bit(v[i]);
    send_bit(1'b1);
  endtask

  task automatic write_reg(input logic cs, input logic [6:0] addr, input logic [7:0] idx,
                           input logic [7:0] data, output logic [2:0] acks);
    chipSelect = cs;
    tick(8);
    start_cond();
    send_byte({addr, 1'b0}, acks[2]);
    send_byte(idx, acks[1]);
    send_byte(data, acks[0]);
    stop_cond();
    chipSelect = 1'b0;
    tick(4);
  endtask

  task automatic read_reg(input logic cs, input logic [6:0] addr, input logic [7:0] idx,
                          output logic [7:0] data, output logic [2:0] acks);
    chipSelect = cs;
    tick(8);
    start_cond();
    send_byte({addr, 1'b0}, acks[2]);
    send_byte(idx, acks[1]);
    start_cond();
    send_byte({addr, 1'b1}, acks[0]);
    recv_byte(data);
    stop_cond();
    chipSelect = 1'b0;
    tick(4);
  endtask

  // two data bytes in one write: the index steps after the first
  task automatic write_pair(input logic [6:0] addr, input logic [7:0] idx,
                            input logic [15:0] data, output logic [3:0] acks);
    chipSelect = 1'b1;
    tick(8);
    start_cond();
    send_byte({addr, 1'b0}, acks[3]);
    send_byte(idx, acks[2]);
    send_byte(data[15:8], acks[1]);
    send_byte(data[7:0], acks[0]);
    stop_cond();
    chipSelect = 1'b0;
    tick(4);
  endtask

  // two data bytes in one read: host acknowledges the first
  task automatic read_pair(input logic [6:0] addr, input logic [7:0] idx,
                           output logic [15:0] data, output logic [2:0] acks);
    chipSelect = 1'b1;
    tick(8);
    start_cond();
    send_byte({addr, 1'b0}, acks[2]);
    send_byte(idx, acks[1]);
    start_cond();
    send_byte({addr, 1'b1}, acks[0]);
    for (int i = 15; i >= 8; i--)
      recv_bit(data[i]);
    send_bit(1'b0);
    recv_byte(data[7:0]);
    stop_cond();
    chipSelect = 1'b0;
    tick(4);
  endtask
endmodule // eqc_host_model

// ==== smbus_lane_config_registers_bench.sv ====
`timescale 1ns/1ps
module smbus_lane_config_registers_bench;
  logic        clk;
  logic        rst_b;
  logic [3:0]  detect;
  logic [3:0]  pins;
  logic        chipSelect;
  logic        sclIn;
  logic        sdaLine;
  logic        sdaOut;
  logic        sdaOe;
  logic [3:0]  laneOutputOn;
  logic [11:0] laneBoost;
  logic [7:0]  assertLvl;
  logic [7:0]  deassertLvl;
  logic [1:0]  swing;
  logic [7:0]  rd;
  logic [2:0]  acks;
  int          errCount  = 0;
  int          nCompared = 0;

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  eqc_smbus_regs u_eqc_smbus_regs (
    .clk(clk), .rst_b(rst_b), .chipSelect(chipSelect), .sclIn(sclIn), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .laneSignalPresent(detect), .laneOutputOnPin(pins),
    .laneOutputOn(laneOutputOn), .laneBoost(laneBoost), .detectAssertLevel(assertLvl),
    .detectDeassertLevel(deassertLvl), .driverSwing(swing)
  );

  eqc_host_model u_eqc_host_model (
    .clk(clk), .sdaOe(sdaOe), .sdaOut(sdaOut), .chipSelect(chipSelect), .sclIn(sclIn),
    .sdaLine(sdaLine)
  );

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    nCompared++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    u_eqc_host_model.write_reg(1'b1, eqc_pkg::SLAVE_ADDRESS, idx, data, acks);
    check(16'(acks), 16'h0000, "write acks");
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    u_eqc_host_model.read_reg(1'b1, eqc_pkg::SLAVE_ADDRESS, idx, rd, acks);
    check(16'(acks), 16'h0000, "read acks");
    check(16'(rd), 16'(exp), "read data");
    check(16'(sdaOe), 16'h0000, "bus not released");
    check(16'(sdaOut), 16'h0000, "open drain value");
  endtask

  task automatic test_reset_values();
    logic [7:0] defaults [3:8];
    defaults = '{8'h44, 8'h44, 8'h00, 8'h00, 8'h00, 8'h78};
    rd_chk(8'h00, {eqc_pkg::REVISION_ID, 4'h9});
    rd_chk(8'h01, 8'hC4);
    rd_chk(8'h02, 8'hC4);
    for (int i = 3; i <= 8; i++)
      rd_chk(8'(i), defaults[i]);
    check(16'(laneBoost), 16'h0924, "boost port");
    check(16'(swing), 16'h0002, "swing port");
    check(16'(laneOutputOn), 16'h000A, "enable from pins");
    check(16'(assertLvl), 16'h0000, "assert level reset");
    check(16'(deassertLvl), 16'h0000, "deassert level reset");
  endtask

  task automatic test_write_readback();
    wr(8'h05, 8'hE4);
    wr(8'h06, 8'h1B);
    wr(8'h03, 8'h8B);
    wr(8'h04, 8'h37);
    wr(8'h08, 8'hFF);
    rd_chk(8'h05, 8'hE4);
    rd_chk(8'h06, 8'h1B);
    rd_chk(8'h03, 8'h8B);
    rd_chk(8'h04, 8'h37);
    rd_chk(8'h08, 8'h7C);
    check(16'(assertLvl), 16'h00E4, "assert level port");
    check(16'(deassertLvl), 16'h001B, "deassert level port");
    check(16'(laneBoost), 16'h07C3, "boost port");
    check(16'(swing), 16'h0003, "swing port");
    wr(8'h08, 8'h34);
    rd_chk(8'h08, 8'h74);
    check(16'(swing), 16'h0001, "swing port");
  endtask

  task automatic test_readonly_reserved();
    for (int i = 0; i < 3; i++)
      wr(8'(i), 8'hFF);
    wr(8'h09, 8'hFF);
    detect = 4'h6;
    rd_chk(8'h00, {eqc_pkg::REVISION_ID, 4'h6});
    rd_chk(8'h01, 8'h83);
    rd_chk(8'h02, 8'hB7);
    rd_chk(8'h09, 8'h00);
    wr(8'h07, 8'hFF);
    rd_chk(8'h07, 8'h01);
  endtask

  task automatic test_source_select();
    check(16'(laneOutputOn), 16'h000C, "enable from register");
    pins = 4'b0010;
    repeat (8) @(posedge clk);
    #1;
    check(16'(laneOutputOn), 16'h000C, "pins ignored");
    rd_chk(8'h01, 8'h03);
    rd_chk(8'h02, 8'hBF);
    wr(8'h07, 8'h00);
    check(16'(laneOutputOn), 16'h0002, "enable from pins");
    rd_chk(8'h01, 8'h83);
  endtask

  task automatic test_ignored_traffic();
    u_eqc_host_model.write_reg(1'b0, eqc_pkg::SLAVE_ADDRESS, 8'h05, 8'h00, acks);
    check(16'(acks), 16'h0007, "deselected acks");
    rd_chk(8'h05, 8'hE4);
    u_eqc_host_model.write_reg(1'b1, 7'h57, 8'h05, 8'h00, acks);
    check(16'(acks), 16'h0007, "foreign address acks");
    rd_chk(8'h05, 8'hE4);
  endtask

  task automatic test_burst();
    logic [3:0]  wacks;
    logic [15:0] pair;
    u_eqc_host_model.write_pair(eqc_pkg::SLAVE_ADDRESS, 8'h05, 16'h2D96, wacks);
    check(16'(wacks), 16'h0000, "burst write acks");
    rd_chk(8'h05, 8'h2D);
    rd_chk(8'h06, 8'h96);
    u_eqc_host_model.read_pair(eqc_pkg::SLAVE_ADDRESS, 8'h05, pair, acks);
    check(16'(acks), 16'h0000, "burst read acks");
    check(pair, 16'h2D96, "burst read data");
    check(16'(deassertLvl), 16'h0096, "deassert level port");
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    errCount++;
    end_of_test();
  end

  initial
  begin
    rst_b  = 1'b0;
    detect = 4'h9;
    pins   = 4'b1010;
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    test_reset_values();
    test_write_readback();
    test_readonly_reserved();
    test_source_select();
    test_ignored_traffic();
    test_burst();
    end_of_test();
  end
endmodule // smbus_lane_config_registers_bench
